// file: screen_cmd_map.vh
`ifndef SCREEN_CMD_MAP_VH
`define SCREEN_CMD_MAP_VH

// APB register byte offsets
`define OFS_CMD_CHAR 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_SCREEN0 8'h10
`define OFS_WALL 8'h20

// Screen config word fields
`define SCR_SEL_LSB 0
`define SCR_HMAG_LSB 4
`define SCR_VMAG_LSB 8
`define SCR_HPOS_LSB 12
`define SCR_VPOS_LSB 16
`define SCR_W 20

// Wall config word fields
`define WALL_SEL_LSB 0
`define WALL_HMAG_LSB 4
`define WALL_VMAG_LSB 8
`define WALL_COL_LSB 12
`define WALL_ROW_LSB 17
`define WALL_VALID_BIT 24
`define WALL_W 25

// Input selector codes and reset values
`define SEL_OPT 2'h1
`define SEL_VID 2'h2
`define SEL_RST 2'h2
`define MAG_RST 4'h1
`define POS_RST 4'h1

// Characters of the command text
`define CH_CR 8'h0D
`define CH_STAR 8'h2A
`define CH_A 8'h41
`define CH_B 8'h42
`define CH_C 8'h43
`define CH_D 8'h44
`define CH_M 8'h4D

// Command buffer depth, longest command plus trailing letter
`define BUF_DEPTH 9
`define LEN_B 4'h8
`define LEN_M 4'h6
`define LEN_D 4'h4

`endif

// file: char_nibble.v
`timescale 1ns/1ps
`default_nettype none
// Turns one command character into a hex nibble with class flags
module char_nibble
(
  input wire [7:0] char_i,
  output reg [3:0] nib_o,
  output reg is_hex_o,
  output reg is_18_o
);

  //////////////////////////////////////////////////////////////////////
  // Upper-case hex only; lower case is not part of the command set
  always @*
  begin
    nib_o = 4'h0;
    is_hex_o = 1'b0;
    if (char_i >= 8'h30 && char_i <= 8'h39)
    begin
      nib_o = char_i[3:0];
      is_hex_o = 1'b1;
    end
    else if (char_i >= 8'h41 && char_i <= 8'h46)
    begin
      nib_o = char_i[3:0] + 4'h9;
      is_hex_o = 1'b1;
    end
    // Digits 1 to 8 serve for every size field and for the position fields of the B command
    is_18_o = (char_i >= 8'h31) && (char_i <= 8'h38);
  end

endmodule // char_nibble
`default_nettype wire

// file: wall_origin_decode.v
`timescale 1ns/1ps
`default_nettype none
// Maps a matrix screen code onto signed wall coordinates
module wall_origin_decode
(
  input wire [3:0] col_code_i,
  input wire [3:0] row_code_i,
  input wire [3:0] hmag_i,
  input wire [3:0] vmag_i,
  output reg [4:0] col_o,
  output reg [4:0] row_o,
  output reg ok_o
);

  reg [5:0] hend; // Column just past the image's right edge
  reg [5:0] vend; // Row just past the image's bottom edge

  //////////////////////////////////////////////////////////////////////
  // Codes 1-8 are physical (0..7), 9-F imaginary (-7..-1)
  always @*
  begin
    if (col_code_i <= 4'h8)
      col_o = {1'b0, col_code_i} - 5'h01;
    else
      col_o = {1'b0, col_code_i} - 5'h10;
    if (row_code_i <= 4'h8)
      row_o = {1'b0, row_code_i} - 5'h01;
    else
      row_o = {1'b0, row_code_i} - 5'h10;
    // The image must reach at least column 0 and row 0
    hend = {col_o[4], col_o} + {2'h0, hmag_i};
    vend = {row_o[4], row_o} + {2'h0, vmag_i};
    // Digit 0 in either place falls in the invalid area
    ok_o = (col_code_i != 4'h0) && (row_code_i != 4'h0)
      && !hend[5] && (hend != 6'h00)
      && !vend[5] && (vend != 6'h00);
  end

endmodule // wall_origin_decode
`default_nettype wire

// file: video_wall_screen_command.v
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "screen_cmd_map.vh"
// Text command interpreter for four tile ports and a matrix wall
module video_wall_screen_command
#(
  parameter SCREENS = 4
)
(
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  output wire [SCREENS*`SCR_W-1:0] video_tile_port_o,
  output wire [`WALL_W-1:0] wall_cfg_o,
  output wire mono_o,
  output reg cmd_done_o,
  output reg cmd_reject_o
);

  //////////////////////////////////////////////////////////////////////
  // Storage

  reg [7:0] raw_q [0:`BUF_DEPTH-1]; // Received characters
  reg [3:0] nib_q [0:`BUF_DEPTH-1]; // Hex value of each character
  reg hex_q [0:`BUF_DEPTH-1]; // Character was a hex digit
  reg d18_q [0:`BUF_DEPTH-1]; // Character was a digit 1 to 8
  reg [3:0] len_q; // Characters held so far
  reg ovf_q; // Text ran past the buffer
  reg [1:0] sel_q [0:SCREENS-1]; // Per screen input selection
  reg [3:0] hmag_q [0:SCREENS-1]; // Per screen horizontal factor
  reg [3:0] vmag_q [0:SCREENS-1]; // Per screen vertical factor
  reg [3:0] hpos_q [0:SCREENS-1]; // Per screen tile column
  reg [3:0] vpos_q [0:SCREENS-1]; // Per screen tile row
  reg [`WALL_W-1:0] wall_q; // Wall origin, factors and input
  reg mono_q; // Monochrome display active
  reg ok_last_q; // Last command was carried out
  reg rej_last_q; // Last command was refused

  wire access = psel_i && penable_i; // Access phase edge
  wire setup = psel_i && !penable_i; // Setup phase edge
  wire wr_char = access && pwrite_i && (paddr_i == `OFS_CMD_CHAR);
  wire wr_ctrl = access && pwrite_i && (paddr_i == `OFS_CTRL);

  // Always ready: every access completes in one wait-free phase
  assign pready_o = 1'b1;
  assign wall_cfg_o = wall_q;
  assign mono_o = mono_q;

  //////////////////////////////////////////////////////////////////////
  // Decoders

  wire [3:0] in_nib; // Hex value of the arriving character
  wire in_hex; // Arriving character is hex
  wire in_18; // Arriving character is 1 to 8

  char_nibble u_char
  (
    .char_i(pwdata_i[7:0]),
    .nib_o(in_nib),
    .is_hex_o(in_hex),
    .is_18_o(in_18)
  );

  wire [4:0] org_col; // Wall column of the origin
  wire [4:0] org_row; // Wall row of the origin
  wire org_ok; // Origin legal and image meets the wall

  wall_origin_decode u_wall
  (
    .col_code_i(nib_q[1]),
    .row_code_i(nib_q[2]),
    .hmag_i(nib_q[4]),
    .vmag_i(nib_q[5]),
    .col_o(org_col),
    .row_o(org_row),
    .ok_o(org_ok)
  );

  //////////////////////////////////////////////////////////////////////
  // Command check, evaluated against the buffer when CR arrives

  reg [3:0] base_len; // Length without trailing letter
  reg len_ok; // Length matches the command form
  reg keep_mono; // Trailing B present
  reg tgt_one; // Screen field names a single port
  reg tgt_all; // Screen field names every port
  reg sel_ok; // Input field is A, C or asterisk
  reg sel_keep; // Input field is asterisk
  reg [1:0] sel_new; // Selector code for A or C
  reg exec_b; // Placement command accepted
  reg exec_m; // Wall command accepted
  reg exec_d; // Distributed command accepted

  always @*
  begin
    base_len = 4'h0;
    case (raw_q[0])
      `CH_B: base_len = `LEN_B;
      `CH_M: base_len = `LEN_M;
      `CH_D: base_len = `LEN_D;
      default: base_len = 4'h0;
    endcase
    keep_mono = 1'b0;
    len_ok = 1'b0;
    if (base_len != 4'h0 && !ovf_q)
    begin
      if (len_q == base_len)
        len_ok = 1'b1;
      else if (len_q == base_len + 4'h1 && raw_q[base_len[3:0]] == `CH_B)
      begin
        len_ok = 1'b1;
        keep_mono = 1'b1;
      end
    end
    // 00..03 is one port, FF is all of them
    tgt_one = hex_q[1] && hex_q[2] && nib_q[1] == 4'h0 && nib_q[2] <= 4'h3;
    tgt_all = hex_q[1] && hex_q[2] && nib_q[1] == 4'hF && nib_q[2] == 4'hF;
    sel_keep = (raw_q[3] == `CH_STAR);
    sel_new = (raw_q[3] == `CH_A) ? `SEL_OPT : `SEL_VID;
    // Input B belongs to another system and is refused here
    sel_ok = sel_keep || raw_q[3] == `CH_A || raw_q[3] == `CH_C;
    // Tile position may not lie beyond the magnified image
    exec_b = len_ok && raw_q[0] == `CH_B && (tgt_one || tgt_all) && sel_ok
      && d18_q[4] && d18_q[5] && d18_q[6] && d18_q[7]
      && nib_q[6] <= nib_q[4] && nib_q[7] <= nib_q[5];
    exec_m = len_ok && raw_q[0] == `CH_M && hex_q[1] && hex_q[2] && sel_ok
      && d18_q[4] && d18_q[5] && org_ok;
    exec_d = len_ok && raw_q[0] == `CH_D && (tgt_one || tgt_all) && sel_ok;
  end

  wire exec_any = exec_b || exec_m || exec_d; // Something will change
  wire eoc = wr_char && (pwdata_i[7:0] == `CH_CR); // End of command

  //////////////////////////////////////////////////////////////////////
  // Character buffer; CR ends a command and empties it

  integer k;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      len_q <= 4'h0;
      ovf_q <= 1'b0;
      for (k = 0; k < `BUF_DEPTH; k = k + 1)
      begin
        raw_q[k] <= 8'h00;
        nib_q[k] <= 4'h0;
        hex_q[k] <= 1'b0;
        d18_q[k] <= 1'b0;
      end
    end
    else if (eoc)
    begin
      len_q <= 4'h0;
      ovf_q <= 1'b0;
    end
    else if (wr_char)
    begin
      if (len_q < `BUF_DEPTH)
      begin
        raw_q[len_q] <= pwdata_i[7:0];
        nib_q[len_q] <= in_nib;
        hex_q[len_q] <= in_hex;
        d18_q[len_q] <= in_18;
        len_q <= len_q + 4'h1;
      end
      else
        // Too long for any form; the command will be refused
        ovf_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per screen state; only the addressed ports take the command

  integer s;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (s = 0; s < SCREENS; s = s + 1)
      begin
        sel_q[s] <= `SEL_RST;
        hmag_q[s] <= `MAG_RST;
        vmag_q[s] <= `MAG_RST;
        hpos_q[s] <= `POS_RST;
        vpos_q[s] <= `POS_RST;
      end
    end
    else if (eoc && (exec_b || exec_d))
    begin
      for (s = 0; s < SCREENS; s = s + 1)
      begin
        // Other screens keep their picture untouched
        if (tgt_all || nib_q[2] == s[3:0])
        begin
          if (!sel_keep)
            sel_q[s] <= sel_new;
          if (exec_b)
          begin
            hmag_q[s] <= nib_q[4];
            vmag_q[s] <= nib_q[5];
            hpos_q[s] <= nib_q[6];
            vpos_q[s] <= nib_q[7];
          end
          else
          begin
            hmag_q[s] <= `MAG_RST;
            vmag_q[s] <= `MAG_RST;
            hpos_q[s] <= `POS_RST;
            vpos_q[s] <= `POS_RST;
          end
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SCREENS; g = g + 1)
    begin : g_port
      assign video_tile_port_o[g*`SCR_W +: `SCR_W] =
        {vpos_q[g], hpos_q[g], vmag_q[g], hmag_q[g], 2'h0, sel_q[g]};
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Wall state, mono flag and command result

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wall_q <= {`WALL_W{1'b0}};
      mono_q <= 1'b0;
      ok_last_q <= 1'b0;
      rej_last_q <= 1'b0;
      cmd_done_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end
    else
    begin
      cmd_done_o <= eoc && exec_any;
      cmd_reject_o <= eoc && !exec_any;
      if (eoc)
      begin
        ok_last_q <= exec_any;
        rej_last_q <= !exec_any;
        if (exec_any && !keep_mono)
          mono_q <= 1'b0;
      end
      else if (wr_ctrl)
        mono_q <= pwdata_i[0];
      if (eoc && exec_m)
      begin
        wall_q[`WALL_HMAG_LSB +: 4] <= nib_q[4];
        wall_q[`WALL_VMAG_LSB +: 4] <= nib_q[5];
        wall_q[`WALL_COL_LSB +: 5] <= org_col;
        wall_q[`WALL_ROW_LSB +: 5] <= org_row;
        wall_q[`WALL_VALID_BIT] <= 1'b1;
        if (!sel_keep)
          wall_q[`WALL_SEL_LSB +: 2] <= sel_new;
        else if (!wall_q[`WALL_VALID_BIT])
          wall_q[`WALL_SEL_LSB +: 2] <= `SEL_RST;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // APB read data and error, captured in the setup phase

  reg [31:0] rd_d; // Read word for the addressed register
  reg err_d; // Address not mapped
  always @*
  begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr_i)
      `OFS_CMD_CHAR: rd_d = {28'h000_0000, len_q};
      `OFS_CTRL: rd_d = {31'h0000_0000, mono_q};
      `OFS_STATUS: rd_d = {29'h0000_0000, ovf_q, rej_last_q, ok_last_q};
      `OFS_WALL: rd_d = {7'h00, wall_q};
      default:
      begin
        if (paddr_i >= `OFS_SCREEN0 && paddr_i < `OFS_SCREEN0 + 8'h10
          && paddr_i[1:0] == 2'h0)
          rd_d = {12'h000, video_tile_port_o[paddr_i[3:2]*`SCR_W +: `SCR_W]};
        else
          err_d = 1'b1;
      end
    endcase
  end

  // Registered so data and error are flop outputs in the access phase
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
      pslverr_o <= err_d;
    end
    else if (access)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

endmodule // video_wall_screen_command
`default_nettype wire

// file: screen_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "screen_cmd_map.vh"
// Port-level watcher for the command interpreter
module screen_cmd_props
#(
  parameter SCREENS = 4
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [SCREENS*`SCR_W-1:0] video_tile_port_o,
  input wire logic [`WALL_W-1:0] wall_cfg_o,
  input wire logic mono_o,
  input wire logic cmd_done_o,
  input wire logic cmd_reject_o
);
  // Write taken at an access edge
  wire logic acc = psel_i & penable_i & pwrite_i;
  // Execute character, the only cause of a verdict
  wire logic cr = acc & (paddr_i == `OFS_CMD_CHAR) & (pwdata_i[7:0] == `CH_CR);
  // Control write, the only other way mono moves
  wire logic ctl = acc & (paddr_i == `OFS_CTRL);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  a_one_verdict: assert property (cr |=> cmd_done_o ^ cmd_reject_o)
    else $error("execute gave no single verdict");
  a_verdict_cause: assert property ((cmd_done_o | cmd_reject_o) |-> $past(cr))
    else $error("verdict without execute");
  // State moved at the execute edge, so compare against the edge before
  a_reject_keeps: assert property (cmd_reject_o |-> mono_o == $past(mono_o)
    && video_tile_port_o == $past(video_tile_port_o) && wall_cfg_o == $past(wall_cfg_o))
    else $error("refused command altered state");
  a_tiles_on_done: assert property ((video_tile_port_o != $past(video_tile_port_o))
    |-> cmd_done_o)
    else $error("tile port changed without accepted command");
  a_wall_on_done: assert property ((wall_cfg_o != $past(wall_cfg_o)) |-> cmd_done_o)
    else $error("wall changed without accepted command");
  a_mono_cause: assert property ((mono_o != $past(mono_o))
    |-> $past(ctl) || (cmd_done_o && !mono_o))
    else $error("mono moved without cause");
  a_wall_overlap: assert property (wall_cfg_o[24] |-> wall_cfg_o[7:4] inside {[1:8]}
    && wall_cfg_o[11:8] inside {[1:8]} && $signed(wall_cfg_o[16:12]) < 8
    && $signed(wall_cfg_o[21:17]) < 8
    && ($signed(wall_cfg_o[16:12]) + $signed({1'b0, wall_cfg_o[7:4]})) > 0
    && ($signed(wall_cfg_o[21:17]) + $signed({1'b0, wall_cfg_o[11:8]})) > 0)
    else $error("wall image misses the physical screens");
  genvar i;
  // Every tile keeps legal fields; position never beyond magnification
  for (i = 0; i < SCREENS; i = i + 1)
  begin : g_scr
    wire logic [19:0] s = video_tile_port_o[i*`SCR_W +: `SCR_W];
    a_tile_fields: assert property ((s[1:0] == 2'h1 || s[1:0] == 2'h2)
      && s[7:4] inside {[1:8]} && s[11:8] inside {[1:8]} && s[15:12] >= 1
      && s[15:12] <= s[7:4] && s[19:16] >= 1 && s[19:16] <= s[11:8])
      else $error("tile field out of range");
  end
endmodule // screen_cmd_props
bind video_wall_screen_command screen_cmd_props #(.SCREENS(SCREENS)) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .mono_o(mono_o),
  .video_tile_port_o(video_tile_port_o), .wall_cfg_o(wall_cfg_o),
  .cmd_done_o(cmd_done_o), .cmd_reject_o(cmd_reject_o)
);
`default_nettype wire

// file: host_cmd_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: APB master that types command text one character a write
module host_cmd_model
(
  input wire logic sys_clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output var logic psel_o,
  output var logic penable_o,
  output var logic pwrite_o,
  output var logic [7:0] paddr_o,
  output var logic [31:0] pwdata_o
);
  logic [31:0] rdata; // Data taken mid-cycle in the last access phase
  logic err; // Error flag taken mid-cycle in the last access phase
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end
  // One transfer; request held until pready is seen at a falling edge.
  // Answer lines are read mid-cycle, where the access flops are settled,
  // so the edge that clears them is never raced; no cycle count assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    begin
      @(posedge sys_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      rdy = 1'b0;
      while (rdy !== 1'b1)
      begin
        @(negedge sys_clk_i);
        rdy = pready_i;
        rdata = prdata_i;
        err = pslverr_i;
        @(posedge sys_clk_i);
      end
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Released lines show no stale value
      paddr_o <= ~a;
      pwdata_o <= ~d;
    end
  endtask
  // Whole command then the execute character; only A, C or * and
  // overlapping origins unless a refusal is meant
  task send(input string s);
    integer k;
    begin
      for (k = 0; k < s.len(); k++)
        xfer(1'b1, 8'h00, {24'h00_0000, s[k]});
      xfer(1'b1, 8'h00, 32'h0000_000D);
    end
  endtask
endmodule // host_cmd_model
`default_nettype wire

// file: video_wall_screen_command_tb.sv
`timescale 1ns/1ps
`default_nettype none
module video_wall_screen_command_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mono, done, rej;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [79:0] tiles, t0;
  logic [24:0] wall, w0;
  integer error_cnt = 0;
  integer cmp_count = 0;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  video_wall_screen_command #(.SCREENS(4)) uut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .video_tile_port_o(tiles), .wall_cfg_o(wall), .mono_o(mono),
    .cmd_done_o(done), .cmd_reject_o(rej));
  host_cmd_model host (.sys_clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [79:0] e, input logic [79:0] g);
    begin
      cmp_count++;
      if (e !== g)
      begin
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Verdict pulse stands only in the cycle after the execute edge
  task run(input string s, input logic ok);
    begin
      host.send(s);
      @(negedge clk);
      chk(s, {ok, !ok}, {done, rej});
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      chk("tiles", {4{20'h1_1112}}, tiles);
      host.xfer(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped", 1, host.err);
    end
  endtask
  task t_place;
    begin
      host.xfer(1'b1, 8'h04, 32'h0000_0001);
      run("B01A2212", 1'b1);
      chk("scr", {40'h1_1112_1_1112, 20'h2_1221, 20'h1_1112}, tiles);
      chk("mono", 0, mono);
      host.xfer(1'b0, 8'h14, 32'h0000_0000);
      chk("scr1 reg", 20'h2_1221, host.rdata);
    end
  endtask
  task t_keep;
    begin
      host.xfer(1'b1, 8'h04, 32'h0000_0001);
      run("BFF*8888B", 1'b1);
      chk("all", {40'h8_8882_8_8882, 20'h8_8881, 20'h8_8882}, tiles);
      chk("mono", 1, mono);
    end
  endtask
  task t_refuse;
    string bad[10];
    integer k;
    begin
      bad = '{"B04A1111", "B00A9111", "B00A0111", "B00A1121", "B00Z1111", "D03B",
        "M99A77", "M10A11", "M91C22", "B00A1111BB"};
      t0 = tiles;
      w0 = wall;
      for (k = 0; k < 10; k++)
        run(bad[k], 1'b0);
      host.xfer(1'b0, 8'h08, 32'h0000_0000);
      chk("status", 3'h2, host.rdata);
      chk("tiles", t0, tiles);
      chk("wall", w0, wall);
      chk("mono", 1, mono);
    end
  endtask
  task t_wall;
    string cmd[6];
    logic [24:0] exp[6];
    integer k;
    begin
      cmd = '{"M91C81", "M19A18", "MFFA22B", "M88C11", "M99A88", "M11A22"};
      exp = '{25'h101_9182, 25'h132_0811, 25'h13F_F221, 25'h10E_7112, 25'h133_9881,
        25'h100_0221};
      t0 = tiles;
      for (k = 0; k < 6; k++)
      begin
        run(cmd[k], 1'b1);
        chk(cmd[k], exp[k], wall);
      end
      chk("tiles", t0, tiles);
      chk("mono", 0, mono);
      host.xfer(1'b0, 8'h20, 32'h0000_0000);
      chk("wall reg", 25'h100_0221, host.rdata);
    end
  endtask
  task t_dist;
    begin
      run("BFFC4433", 1'b1);
      run("D02A", 1'b1);
      chk("d02", {20'h3_3442, 20'h1_1111, 40'h3_3442_3_3442}, tiles);
      run("DFF*", 1'b1);
      chk("dff", {20'h1_1112, 20'h1_1111, 40'h1_1112_1_1112}, tiles);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_place;
    t_keep;
    t_refuse;
    t_wall;
    t_dist;
    stop_test;
  end
endmodule // video_wall_screen_command_tb
`default_nettype wire
